// [src/dfs_pkg.sv]
/*
  Shared constants for the disk fault and self-test supervisor: status
  codes, state codes, local register offsets and time bases.
  Assumes a 50 MHz ref_clk; every time below is in its own unit.
*/
package dfs_pkg;

  // Clock and time base
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;
  localparam int FAN_PERSIST_MS = 400;
  localparam int FAN_PERSIST_TICKS = FAN_PERSIST_MS * 1_000_000 / TICK_NS;
  localparam int FAN_LIMIT = 10;

  // Seek series timing windows in ms ticks
  localparam logic [11:0] ONETRK_MIN_MS = 12'h005;
  localparam logic [11:0] ONETRK_MAX_MS = 12'h0c8;
  localparam logic [11:0] MAXLEN_MIN_MS = 12'h032;
  localparam logic [11:0] MAXLEN_MAX_MS = 12'h3e8;

  // Test geometry
  localparam logic [9:0] CYL_GUARD = 10'h002;
  localparam logic [9:0] CYL_RECAL = 10'h07f;
  localparam logic [9:0] CYL_ONE = 10'h001;
  localparam logic [9:0] CYL_MAX = 10'h2c6;
  localparam logic [4:0] RECAL_SEEKS = 5'h06;
  localparam logic [4:0] SERIES_SEEKS = 5'h10;
  localparam logic [1:0] RECAL_SETS = 2'h3;
  localparam logic [1:0] GAIN_RUNS = 2'h3;

  // Status codes
  localparam logic [7:0] CODE_NMI = 8'h58;
  localparam logic [7:0] CODE_SWI = 8'h59;
  localparam logic [7:0] CODE_FAN_MANY = 8'h5b;
  localparam logic [7:0] CODE_FAN = 8'h5c;
  localparam logic [7:0] CODE_PIA = 8'h5f;
  localparam logic [7:0] CODE_RTZ = 8'h60;
  localparam logic [7:0] CODE_RECAL = 8'h61;
  localparam logic [7:0] CODE_ONETRK = 8'h62;
  localparam logic [7:0] CODE_MAXLEN = 8'h63;
  localparam logic [7:0] CODE_GAIN = 8'h64;
  localparam logic [7:0] CODE_ONE_FAST = 8'h65;
  localparam logic [7:0] CODE_ONE_SLOW = 8'h66;
  localparam logic [7:0] CODE_MAX_FAST = 8'h67;
  localparam logic [7:0] CODE_MAX_SLOW = 8'h68;
  localparam logic [7:0] CODE_PRESEEK = 8'h69;
  localparam logic [7:0] CODE_PASS = 8'h70;
  localparam logic [7:0] CODE_FAULT = 8'h80;
  localparam logic [7:0] CODE_SPEED = 8'h90;
  localparam logic [7:0] FMAP_LO = 8'h58;
  localparam logic [7:0] FMAP_HI = 8'h85;
  localparam logic [7:0] FMAP_OFS = 8'h49;

  // Local registers
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic CTRL_RST = 1'b1;

  typedef enum logic [9:0] {
    ST_INIT = 10'h001,
    ST_RTZT = 10'h002,
    ST_RECAL = 10'h004,
    ST_ONETRK = 10'h008,
    ST_MAXLEN = 10'h010,
    ST_RUN = 10'h020,
    ST_FAULT = 10'h040,
    ST_LOAD = 10'h080,
    ST_FANSTOP = 10'h100,
    ST_HALT = 10'h200
  } dfs_state_t;

endpackage

// [src/dfs_timer_if.sv]
/*
  Carrier between the supervisor and its seek series timer.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
interface dfs_timer_if;
  logic start;
  logic stop;
  logic selMax;
  logic tooFast;
  logic tooSlow;
  modport ctl (output start, output stop, output selMax,
               input tooFast, input tooSlow);
  modport tmr (input start, input stop, input selMax,
               output tooFast, output tooSlow);
endinterface

// [src/dfs_tick_div.sv]
/*
  Divider giving a one-cycle enable pulse every millisecond.
  Assumes a free running ref_clk at the package rate.
*/
`timescale 1ns/100ps
module dfs_tick_div #(
  parameter int TICK_CYCLES = dfs_pkg::TICK_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  output logic tick
);
  import dfs_pkg::*;

  typedef struct packed {
    logic [19:0] cnt;
    logic tick;
  } dfs_div_t;

  dfs_div_t q, c;

  // Count down, pulse on wrap
  always_comb begin
    c = q;
    c.tick = 1'b0;
    if (q.cnt == 20'h00000) begin
      c.cnt = 20'(TICK_CYCLES - 1);
      c.tick = 1'b1;
    end else begin
      c.cnt = q.cnt - 20'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= c;
    end
  end

  assign tick = q.tick;
endmodule

// [src/dfs_series_timer.sv]
/*
  Times one seek series in millisecond ticks and flags a series that
  is shorter or longer than its window. Assumes start and stop pulses.
*/
`timescale 1ns/100ps
module dfs_series_timer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  dfs_timer_if.tmr tif
);
  import dfs_pkg::*;

  typedef struct packed {
    logic run;
    logic [11:0] ms;
    logic fast;
    logic slow;
  } dfs_tmr_t;

  dfs_tmr_t q, c;

  // Saturating count, so a hung series still reads as too slow
  always_comb begin
    c = q;
    if (tif.start) begin
      c.run = 1'b1;
      c.ms = 12'h000;
    end else if (tif.stop) begin
      c.run = 1'b0;
    end else if (q.run && tick && q.ms != 12'hfff) begin
      c.ms = q.ms + 12'h001;
    end
    c.fast = q.ms < (tif.selMax ? MAXLEN_MIN_MS : ONETRK_MIN_MS);
    c.slow = q.ms > (tif.selMax ? MAXLEN_MAX_MS : ONETRK_MAX_MS);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= c;
    end
  end

  assign tif.tooFast = q.fast;
  assign tif.tooSlow = q.slow;
endmodule

// [src/dfs_supervisor.sv]
/*
  Fault and self-test supervisor of a fixed-disk drive: power-up servo
  tests, fan watch, pre-seek fault handling, status lines and code.
  Assumes all inputs synchronous to ref_clk and one-cycle event pulses.
*/
`timescale 1ns/100ps
// Contract
// RQ1 - NMI posts code 58
// RQ2 - Software interrupt posts code 59
// RQ3 - Fan fault over 400 ms stops drive
// RQ4 - Retry fan clear, restart if fault-free
// RQ5 - Tenth fan fault posts 5B, locks
// RQ6 - Interface chip failure: 5F, halt, LEDs
// RQ7 - Fault at seek: 80, lines set
// RQ8 - Voltage fault retracts, else servo floats
// RQ9 - Clear then RETURN_TO_ZERO_SEEK reloads to cylinder 0
// RQ10 - Speed recovery: 90, float until RETURN_TO_ZERO_SEEK
// RQ11 - Guardband RETURN_TO_ZERO_SEEK test, else code 60
// RQ12 - Eighteen recalibrate seeks, else code 61
// RQ13 - Sixteen one-track seeks, else code 62
// RQ14 - Sixteen maximum seeks, else code 63
// RQ15 - Gain differs across runs: code 64
// RQ16 - One-track series timing: 65 or 66
// RQ17 - Maximum series timing: 67 or 68
// RQ18 - Not ready at seek: code 69
// RQ19 - All tests passed: code 70
// RQ20 - Fault line maps codes to A1-CE
// RQ21 - Hold last code until replaced
module dfs_supervisor #(
  parameter int TICK_CYCLES = dfs_pkg::TICK_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic nmiEvt,
  input wire logic swiEvt,
  input wire logic piaDone,
  input wire logic piaOk,
  input wire logic fanFail,
  input wire logic faultPresent,
  input wire logic voltageFault,
  input wire logic driveReady,
  input wire logic hostSeek,
  input wire logic hostRtz,
  input wire logic hostFaultClear,
  input wire logic localClear,
  input wire logic speedRecovered,
  input wire logic seekDone,
  input wire logic seekOk,
  input wire logic [7:0] gainNum,
  output logic seekReq,
  output logic [9:0] seekTarget,
  output logic seekGuard,
  output logic servoEnable,
  output logic headRetract,
  output logic spindleRun,
  output logic fanClearTry,
  output logic allFaultLeds,
  output logic seekError,
  output logic seekEnd,
  output logic ready,
  output logic fault,
  output logic onCylinder,
  output logic [7:0] statusCode
);
  import dfs_pkg::*;

  typedef struct packed {
    dfs_state_t st;
    logic [7:0] code;
    logic [7:0] disp;
    logic seekErr;
    logic seekEnd;
    logic rdy;
    logic flt;
    logic onCyl;
    logic servoEn;
    logic retract;
    logic spin;
    logic leds;
    logic fanTry;
    logic seekReq;
    logic guard;
    logic [9:0] target;
    logic busy;
    logic back;
    logic [4:0] cnt;
    logic [1:0] sets;
    logic [7:0] gain;
    logic [1:0] same;
    logic [8:0] fanMs;
    logic [3:0] fanCnt;
    logic fanLock;
    logic clrArm;
    logic floatRecov;
    logic piaPass;
    logic startEn;
    logic tStart;
    logic tStop;
    logic [31:0] rdata;
  } dfs_core_t;

  dfs_core_t q, c;
  logic tick;
  logic fanTrig;
  logic testSt;
  logic [4:0] nSeeks;
  logic [9:0] tgt;
  logic [7:0] failCode;
  logic [1:0] sameNx;
  dfs_timer_if tif ();

  //////////////////////////////////////////////////////////////////////
  // Millisecond base and series timer

  dfs_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(tick)
  );

  dfs_series_timer u_tmr (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(tick),
    .tif(tif)
  );

  assign tif.start = q.tStart;
  assign tif.stop = q.tStop;
  assign tif.selMax = (q.st == ST_MAXLEN);

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    c = q;
    c.seekReq = 1'b0;
    c.fanTry = 1'b0;
    c.tStart = 1'b0;
    c.tStop = 1'b0;
    c.rdata = 32'h00000000;
    nSeeks = SERIES_SEEKS;
    tgt = CYL_ONE;
    failCode = CODE_ONETRK;
    sameNx = 2'h1;
    testSt = (q.st == ST_RTZT) || (q.st == ST_RECAL) ||
             (q.st == ST_ONETRK) || (q.st == ST_MAXLEN);
    // Register port; unmapped reads return zero
    if (regWr && regAddr == CTRL_OFS) begin
      c.startEn = regWdata[0];
    end
    if (regRd) begin
      if (regAddr == CTRL_OFS) begin
        c.rdata = {31'h00000000, q.startEn};
      end else if (regAddr == STAT_OFS) begin
        c.rdata = {2'h0, q.st, 3'h0, q.fanLock, q.fanCnt, q.onCyl,
                   q.seekErr, q.rdy, q.flt, q.code};
      end
    end
    // Fan persistence count; clears as soon as the fan recovers
    if (!fanFail) begin
      c.fanMs = 9'h000;
    end else if (tick && q.fanMs != 9'(FAN_PERSIST_TICKS)) begin
      c.fanMs = q.fanMs + 9'h001;
    end
    fanTrig = fanFail && tick && q.fanMs == 9'(FAN_PERSIST_TICKS) &&
              q.st != ST_INIT && q.st != ST_HALT && q.st != ST_FANSTOP;
    // Per-test geometry
    case (q.st)
      ST_RTZT: begin
        nSeeks = 5'h01;
        tgt = CYL_GUARD;
        failCode = CODE_RTZ; // RQ11
      end
      ST_RECAL: begin
        nSeeks = RECAL_SEEKS;
        tgt = CYL_RECAL;
        failCode = CODE_RECAL; // RQ12
      end
      ST_MAXLEN: begin
        tgt = CYL_MAX;
        failCode = CODE_MAXLEN; // RQ14
      end
      default: begin
        failCode = CODE_ONETRK; // RQ13
      end
    endcase
    if (fanTrig) begin
      // Stop as for a start-switch stop
      c.st = ST_FANSTOP; // RQ3
      c.spin = 1'b0;
      c.rdy = 1'b0;
      c.onCyl = 1'b0;
      c.servoEn = 1'b0;
      c.busy = 1'b0;
      c.back = 1'b0;
      c.cnt = 5'h00;
      c.sets = 2'h0;
      c.tStop = 1'b1;
      c.fanMs = 9'h000;
      c.fanCnt = q.fanCnt + 4'h1;
      if (q.fanCnt == 4'(FAN_LIMIT - 1)) begin
        c.code = CODE_FAN_MANY; // RQ5
        c.fanLock = 1'b1;
      end else begin
        c.code = CODE_FAN;
      end
    end else if (testSt) begin
      if (!q.busy) begin
        if (!driveReady) begin
          c.code = CODE_PRESEEK; // RQ18
          c.st = ST_FAULT;
          c.flt = 1'b1;
          c.seekErr = 1'b1;
          c.servoEn = 1'b0;
        end else begin
          c.seekReq = 1'b1;
          c.busy = 1'b1;
          c.target = q.back ? 10'h000 : tgt;
          c.guard = (q.st == ST_RTZT) && !q.back; // RQ11
          c.tStart = (q.st == ST_ONETRK || q.st == ST_MAXLEN) &&
                     !q.back && q.cnt == 5'h00;
        end
      end else if (seekDone) begin
        c.busy = 1'b0;
        if (!seekOk) begin
          c.code = failCode;
          c.st = ST_FAULT;
          c.flt = 1'b1;
          c.seekErr = 1'b1;
          c.servoEn = 1'b0;
          c.tStop = 1'b1;
        end else if (!q.back) begin
          c.back = 1'b1;
        end else begin
          c.back = 1'b0;
          c.cnt = q.cnt + 5'h01;
          if (c.cnt == nSeeks) begin
            c.cnt = 5'h00;
            c.tStop = 1'b1;
            case (q.st)
              ST_RTZT: c.st = ST_RECAL;
              ST_RECAL: begin
                // Gain must repeat across all three sets
                if (q.sets != 2'h0 && gainNum == q.gain) begin
                  sameNx = q.same + 2'h1; // RQ15
                end
                c.same = sameNx;
                c.gain = gainNum;
                c.sets = q.sets + 2'h1; // RQ12
                if (c.sets == RECAL_SETS) begin
                  c.sets = 2'h0;
                  if (sameNx != GAIN_RUNS) begin
                    c.code = CODE_GAIN; // RQ15
                    c.st = ST_FAULT;
                    c.flt = 1'b1;
                    c.seekErr = 1'b1;
                    c.servoEn = 1'b0;
                  end else begin
                    c.st = ST_ONETRK;
                  end
                end
              end
              ST_ONETRK: begin
                if (tif.tooFast || tif.tooSlow) begin
                  c.code = tif.tooFast ? CODE_ONE_FAST : CODE_ONE_SLOW; // RQ16
                  c.st = ST_FAULT;
                  c.flt = 1'b1;
                end else begin
                  c.st = ST_MAXLEN;
                end
              end
              default: begin
                if (tif.tooFast || tif.tooSlow) begin
                  c.code = tif.tooFast ? CODE_MAX_FAST : CODE_MAX_SLOW; // RQ17
                  c.st = ST_FAULT;
                  c.flt = 1'b1;
                end else begin
                  c.code = CODE_PASS; // RQ19
                  c.st = ST_RUN;
                  c.rdy = 1'b1;
                  c.onCyl = 1'b1;
                  c.seekErr = 1'b0;
                end
              end
            endcase
          end
        end
      end
    end else begin
      case (q.st)
        ST_INIT: begin
          if (piaDone && !piaOk) begin
            c.code = CODE_PIA; // RQ6
            c.st = ST_HALT;
            c.leds = 1'b1;
            c.flt = 1'b1;
          end else if (piaDone) begin
            c.piaPass = 1'b1;
          end
          if (q.piaPass && q.startEn) begin
            c.st = ST_RTZT;
            c.spin = 1'b1;
            c.servoEn = 1'b1;
          end
        end
        ST_RUN: begin
          if ((hostSeek || hostRtz) && faultPresent) begin
            c.code = CODE_FAULT; // RQ7
            c.st = ST_FAULT;
            c.seekErr = 1'b1;
            c.seekEnd = 1'b1;
            c.flt = 1'b1;
            c.rdy = 1'b0;
            c.onCyl = 1'b0;
            c.servoEn = 1'b0; // RQ8
            c.retract = voltageFault; // RQ8
          end else if (speedRecovered) begin
            c.code = CODE_SPEED; // RQ10
            c.floatRecov = 1'b1;
            c.servoEn = 1'b0;
            c.seekErr = 1'b1;
            c.onCyl = 1'b0;
            c.rdy = 1'b0;
          end else if (hostRtz) begin
            c.seekErr = 1'b0;
            if (q.floatRecov) begin
              c.rdy = 1'b1; // RQ10
              c.onCyl = 1'b1;
              c.servoEn = 1'b1;
              c.floatRecov = 1'b0;
            end
          end
        end
        ST_FAULT: begin
          // Controller clear arms; the following RETURN_TO_ZERO_SEEK reloads
          if (hostFaultClear && !faultPresent) begin
            c.clrArm = 1'b1;
          end
          if (((q.clrArm && hostRtz) || localClear) && !faultPresent) begin
            c.flt = 1'b0; // RQ9
            c.seekErr = 1'b0;
            c.seekEnd = 1'b0;
            c.retract = 1'b0;
            c.servoEn = 1'b1;
            c.clrArm = 1'b0;
            c.seekReq = 1'b1;
            c.target = 10'h000;
            c.guard = 1'b0;
            c.busy = 1'b1;
            c.st = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (seekDone) begin
            c.busy = 1'b0;
            c.st = seekOk ? ST_RUN : ST_FAULT;
            c.rdy = seekOk;
            c.onCyl = seekOk;
            c.flt = !seekOk;
            c.seekErr = !seekOk;
          end
        end
        ST_FANSTOP: begin
          // A locked drive waits for a power cycle
          if (!q.fanLock) begin
            c.fanTry = tick; // RQ4
            if (!fanFail && !faultPresent) begin
              c.st = ST_RTZT; // RQ4
              c.spin = 1'b1;
              c.servoEn = 1'b1;
            end
          end
        end
        default: begin
          c.st = q.st;
        end
      endcase
    end
    // Unexpected processor exceptions win the display
    if (nmiEvt) begin
      c.code = CODE_NMI; // RQ1
    end
    if (swiEvt) begin
      c.code = CODE_SWI; // RQ2
    end
    // Faulted twin of a no-fault error code
    c.disp = c.code; // RQ21
    if (c.flt && c.code >= FMAP_LO && c.code <= FMAP_HI &&
        c.code != CODE_FAULT && c.code != CODE_PASS) begin
      c.disp = c.code + FMAP_OFS; // RQ20
    end
  end

  // State register; resets to zero apart from the start enable and the ST_INIT state code
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{st: ST_INIT, startEn: CTRL_RST, default: '0};
    end else begin
      q <= c;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign regRdata = q.rdata;
  assign seekReq = q.seekReq;
  assign seekTarget = q.target;
  assign seekGuard = q.guard;
  assign servoEnable = q.servoEn;
  assign headRetract = q.retract;
  assign spindleRun = q.spin;
  assign fanClearTry = q.fanTry;
  assign allFaultLeds = q.leds;
  assign seekError = q.seekErr;
  assign seekEnd = q.seekEnd;
  assign ready = q.rdy;
  assign fault = q.flt;
  assign onCylinder = q.onCyl;
  assign statusCode = q.disp;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence preseek_hit_s;
    q.st == ST_RUN && (hostSeek || hostRtz) && faultPresent &&
    !fanTrig && !nmiEvt && !swiEvt;
  endsequence

  sequence float_hold_s;
    (q.floatRecov && !q.rdy && q.seekErr) ##1 (!q.rdy || $past(hostRtz));
  endsequence

  nmi_code_a: assert property ( // RQ1
    nmiEvt && !swiEvt |=> q.code == CODE_NMI)
    else $error("nmi code not posted");
  swi_code_a: assert property ( // RQ2
    swiEvt |=> q.code == CODE_SWI)
    else $error("swi code not posted");
  fan_stop_a: assert property ( // RQ3
    fanTrig |=> q.st == ST_FANSTOP && !spindleRun && !ready)
    else $error("fan fault did not stop drive");
  fan_lock_a: assert property ( // RQ5
    q.fanLock && q.st == ST_FANSTOP |-> ##1 !fanClearTry [*3])
    else $error("locked fan still retried");
  pia_halt_a: assert property ( // RQ6
    q.st == ST_INIT && piaDone && !piaOk && !nmiEvt && !swiEvt |=>
    q.st == ST_HALT && allFaultLeds && q.code == CODE_PIA ##1
    q.st == ST_HALT)
    else $error("interface chip failure not halted");
  preseek_lines_a: assert property ( // RQ7
    preseek_hit_s |=> fault && seekError && seekEnd && !ready &&
    q.code == CODE_FAULT)
    else $error("pre-seek fault lines wrong");
  retract_sel_a: assert property ( // RQ8
    preseek_hit_s |=> headRetract == $past(voltageFault) && !servoEnable)
    else $error("retract choice wrong");
  speed_float_a: assert property ( // RQ10
    q.st == ST_RUN && speedRecovered && !hostSeek && !hostRtz &&
    !fanTrig |=> float_hold_s)
    else $error("speed recovery not floating");
  pass_code_a: assert property ( // RQ19
    q.st == ST_MAXLEN && c.st == ST_RUN && !nmiEvt && !swiEvt |=>
    q.code == CODE_PASS && ready && onCylinder)
    else $error("pass code missing");
  fault_map_a: assert property ( // RQ20
    fault && q.code == CODE_RTZ |-> statusCode == 8'ha9)
    else $error("faulted code not mapped");
endmodule

// [testbench/dfs_servo_model.sv]
/*
  Servo engine model for the supervisor's seek link.
  Assumes one-cycle seekReq pulses; latency and outcome come from the bench.
*/
`timescale 1ns/100ps
module dfs_servo_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic seekReq,
  input wire logic [7:0] lat,
  input wire logic okIn,
  output logic seekDone,
  output logic seekOk
);
  logic [7:0] cntQ;
  logic busyQ;

  ////////////////////////////////////////////////////////////////////////
  // One answer per request; seekOk toggles outside the done pulse so a
  // stale value is never mistaken for a result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cntQ <= 8'h00;
      busyQ <= 1'b0;
      seekDone <= 1'b0;
      seekOk <= 1'b0;
    end else begin
      seekDone <= 1'b0;
      seekOk <= ~seekOk;
      if (seekReq) begin
        busyQ <= 1'b1;
        cntQ <= lat;
      end else if (busyQ && cntQ <= 8'h01) begin
        busyQ <= 1'b0;
        seekDone <= 1'b1;
        seekOk <= okIn;
      end else if (busyQ) begin
        cntQ <= cntQ - 8'h01;
      end
    end
  end
endmodule

// [testbench/dfs_supervisor_bench.sv]
/*
  Self-checking bench for the fault and self-test supervisor.
  Assumes the servo model file and a four-cycle millisecond tick.
*/
`timescale 1ns/100ps
module dfs_supervisor_bench;
  import dfs_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [7:0] ev = 8'h00, lat = 8'h0a, gainNum = 8'h3c, statusCode;
  logic nmiEvt, swiEvt, piaDone, hostSeek, hostRtz, hostFaultClear;
  logic localClear, speedRecovered, seekDone, seekOk, seekReq;
  logic piaOk = 1'b1, fanFail = 1'b0, faultPresent = 1'b0;
  logic voltageFault = 1'b0, driveReady = 1'b1, okIn = 1'b1, gRnd = 1'b0;
  logic [9:0] seekTarget, lastTgt, firstT;
  logic seekGuard, servoEnable, headRetract, spindleRun, fanClearTry;
  logic allFaultLeds, seekError, seekEnd, ready, fault, onCylinder, firstG;
  int fails = 0, n_compared = 0, cyc = 0, seed = 6834, nTry = 0, v;
  int cnt [0:3];

  // Event pulses share one vector so a single task drives them all
  assign {speedRecovered, localClear, hostFaultClear, hostRtz, hostSeek,
          swiEvt, nmiEvt, piaDone} = ev;

  always #10 ref_clk = ~ref_clk;

  dfs_supervisor #(.TICK_CYCLES(TK)) i_dfs_supervisor (.ref_clk, .resetn,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .nmiEvt, .swiEvt,
    .piaDone, .piaOk, .fanFail, .faultPresent, .voltageFault, .driveReady,
    .hostSeek, .hostRtz, .hostFaultClear, .localClear, .speedRecovered,
    .seekDone, .seekOk, .gainNum, .seekReq, .seekTarget, .seekGuard,
    .servoEnable, .headRetract, .spindleRun, .fanClearTry, .allFaultLeds,
    .seekError, .seekEnd, .ready, .fault, .onCylinder, .statusCode);

  dfs_servo_model i_dfs_servo_model (.ref_clk, .resetn, .seekReq, .lat,
    .okIn, .seekDone, .seekOk);

  ////////////////////////////////////////////////////////////////////////
  // Seek bookkeeping, random gain, and the hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (fanClearTry === 1'b1) nTry++;
    if (seekReq === 1'b1) begin
      if (cnt[0] == 0) {firstG, firstT} = {seekGuard, seekTarget};
      cnt[0]++;
      lastTgt = seekTarget;
      cnt[1] += int'(seekTarget === 10'h07f);
      cnt[2] += int'(seekTarget === 10'h001);
      cnt[3] += int'(seekTarget === 10'h2c6);
    end
    if (gRnd) gainNum <= 8'($random(seed));
    if (cyc == 60000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic hit(input int k);
    @(posedge ref_clk);
    ev <= 8'h01 << k;
    @(posedge ref_clk);
    ev <= 8'h00;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= w;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic chkC(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkB(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Raw code is read from the status word, so display mapping stays apart
  task automatic raw(input logic [7:0] e);
    rd(STAT_OFS);
    chkC(d[7:0], e);
  endtask

  function automatic logic [7:0] shown(input logic [7:0] r, input logic f);
    if (f && r >= FMAP_LO && r <= FMAP_HI && r != 8'h70 && r != 8'h80)
      return r + FMAP_OFS;
    return r;
  endfunction

  function automatic logic cnd(input int k);
    case (k)
      0: return ready;
      1: return fault;
      default: return !spindleRun;
    endcase
  endfunction

  task automatic waitc(input int k, input int lim);
    int i;
    for (i = 0; i < lim && cnd(k) !== 1'b1; i++) @(posedge ref_clk);
    if (i == lim) begin
      fails++;
      $display("ERROR t=%0t wait %h lim %h", $time, k, lim);
    end
    repeat (2) @(negedge ref_clk);
  endtask

  // Latency jitter stays inside both timing windows
  function automatic logic [7:0] rl();
    return 8'h08 + 8'($random(seed) & 3);
  endfunction

  task automatic boot(input logic [7:0] l, input logic ok, input logic p);
    @(posedge ref_clk);
    resetn <= 1'b0;
    lat <= l;
    okIn <= ok;
    piaOk <= p;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    cnt = '{0, 0, 0, 0};
    hit(0);
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cnt = '{0, 0, 0, 0};
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chkC(statusCode, 8'h00);
    rd(CTRL_OFS);
    chkB(d[0], 1'b1);
    rd(4'h8);
    chkC(d[7:0] | d[31:24], 8'h00);
    wr(CTRL_OFS, 32'h0);
    rd(CTRL_OFS);
    chkB(d[0], 1'b0);
    hit(0);
    repeat (40) @(posedge ref_clk);
    chkC(8'(cnt[0]), 8'h00);
    fin("regs");
    boot(rl(), 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    raw(8'h5f);
    chkB(allFaultLeds, 1'b1);
    chkC(8'(cnt[0]), 8'h00);
    driveReady <= 1'b0;
    boot(rl(), 1'b1, 1'b1);
    waitc(1, 200);
    raw(8'h69);
    driveReady <= 1'b1;
    boot(rl(), 1'b0, 1'b1);
    waitc(1, 200);
    raw(8'h60);
    gRnd <= 1'b1;
    boot(rl(), 1'b1, 1'b1);
    waitc(1, 2000);
    raw(8'h64);
    gRnd <= 1'b0;
    boot(8'h1e, 1'b1, 1'b1);
    waitc(1, 4000);
    raw(8'h66);
    chkC(statusCode, shown(8'h66, 1'b1));
    boot(8'h01, 1'b1, 1'b1);
    waitc(1, 800);
    raw(8'h67);
    fin("faults");
    boot(rl(), 1'b1, 1'b1);
    waitc(0, 3000);
    raw(8'h70);
    chkC(statusCode, 8'h70);
    chkB(firstG, 1'b1);
    chkC(firstT[7:0], 8'h02);
    chkC(8'(cnt[1]), 8'h12);
    chkC(8'(cnt[2]), 8'h10);
    chkC(8'(cnt[3]), 8'h10);
    hit(1);
    raw(8'h58);
    hit(2);
    raw(8'h59);
    fin("selftest");
    v = $random(seed);
    voltageFault <= v[0];
    faultPresent <= 1'b1;
    hit(3);
    repeat (2) @(negedge ref_clk);
    raw(8'h80);
    chkC(statusCode, 8'h80);
    chkB(seekError & seekEnd & fault & ~ready, 1'b1);
    chkB(headRetract, v[0]);
    chkB(servoEnable | ~spindleRun, 1'b0);
    // Host clear then RETURN_TO_ZERO_SEEK first, then the local switch
    for (int k = 0; k < 2; k++) begin
      faultPresent <= 1'b0;
      if (k == 0) hit(5);
      hit(k == 0 ? 4 : 6);
      waitc(0, 500);
      chkC(lastTgt[7:0], 8'h00);
      chkB(onCylinder & ~fault, 1'b1);
      if (k == 0) begin
        faultPresent <= 1'b1;
        hit(4);
        waitc(1, 50);
        raw(8'h80);
      end
    end
    hit(7);
    repeat (2) @(negedge ref_clk);
    chkB(seekError & ~ready & ~onCylinder, 1'b1);
    raw(8'h90);
    hit(4);
    waitc(0, 500);
    chkB(onCylinder, 1'b1);
    fin("host");
    // Ten fan stops; the persistence check lands just short of 400 ms
    for (int i = 1; i <= 10; i++) begin
      fanFail <= 1'b1;
      repeat (390 * TK) @(posedge ref_clk);
      chkB(spindleRun, 1'b1);
      waitc(2, 200);
      nTry = 0;
      raw(i < 10 ? 8'h5c : 8'h5b);
      repeat (10 * TK) @(posedge ref_clk);
      chkB(nTry != 0, i < 10);
      fanFail <= 1'b0;
      if (i < 10) waitc(0, 3000);
      chkB(spindleRun, i < 10);
    end
    repeat (200) @(posedge ref_clk);
    chkB(spindleRun, 1'b0);
    fin("fan");
    tally_and_finish();
  end
endmodule
